// *** hdl/fcfe_host.sv ***
// Purpose: Host controller driving the flash front end through its pins.
// Assumes: Data pins are two-way; output enable low means this side drives.
// Notes: One request at a time; req_ready low while a cycle runs.
module fcfe_host
  import fcfe_pkg::*;
#(
  parameter int ADDR_W = FCFE_ADDR_W,
  parameter int DATA_W = FCFE_DATA_W
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire fcfe_pkg::fcfe_op_t req_op,
  input wire logic [ADDR_W-1:0] req_addr,
  input wire logic [DATA_W-1:0] req_wdata,
  input wire logic wp_allow,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_rdata,
  output logic vpp_high,
  output logic [ADDR_W-1:0] mem_addr,
  output logic chip_sel_n,
  output logic out_gate_n,
  output logic wr_strobe_n,
  input wire logic [DATA_W-1:0] dq_in,
  output logic [DATA_W-1:0] dq_out,
  output logic dq_oe_n
);
  import fcfe_pkg::*;
  // ----------------------------------------
  // Input synchronisers and timer
  // ----------------------------------------
  logic [DATA_W-1:0] dq_meta; // First stage, read only by dq_sync
  logic [DATA_W-1:0] dq_sync; // Second stage, safe to sample
  logic wp_meta; // First stage of write-protect strap
  logic wp_sync; // Second stage
  fcfe_state_t state; // Sequencer state
  fcfe_op_t op; // Operation in progress
  fcfe_timer_if tmr_if ();
  fcfe_timer u_timer (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tmr(tmr_if.timer)
  );
  // Device data and protect pin are asynchronous to core_clk
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dq_meta <= '0;
      dq_sync <= '0;
      wp_meta <= 1'b0;
      wp_sync <= 1'b0;
    end else begin
      dq_meta <= dq_in;
      dq_sync <= dq_meta;
      wp_meta <= wp_allow;
      wp_sync <= wp_meta;
    end
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  logic take; // Request accepted this cycle
  logic vpp_allowed; // Supply may rise only with hardware permission
  assign take = req_ready && req_valid;
  assign vpp_allowed = wp_sync;
  // Timer loads on each change into setup, strobe, hold or supply wait
  always_comb begin
    tmr_if.load = 1'b0;
    tmr_if.count = FCFE_CNT_W'(FCFE_SETUP_CYC);
    case (state)
      FCFE_ST_IDLE: begin
        if (take && (req_op == FCFE_OP_VPP_ON || req_op == FCFE_OP_VPP_OFF)) begin
          tmr_if.load = 1'b1;
          tmr_if.count = FCFE_CNT_W'(FCFE_VPP_CYC);
        end else if (take) begin
          tmr_if.load = 1'b1;
        end
      end
      FCFE_ST_SETUP: begin
        if (tmr_if.expired) begin
          tmr_if.load = 1'b1;
          // Reads wait the access time; writes the strobe width
          tmr_if.count = (op == FCFE_OP_READ) ? FCFE_CNT_W'(FCFE_ACC_CYC)
                                              : FCFE_CNT_W'(FCFE_WP_CYC);
        end
      end
      FCFE_ST_STROBE: begin
        if (tmr_if.expired) begin
          tmr_if.load = 1'b1;
          tmr_if.count = FCFE_CNT_W'(FCFE_HOLD_CYC);
        end
      end
      default: begin
        tmr_if.load = 1'b0;
      end
    endcase
  end
  // State advance on each timer expiry
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= FCFE_ST_IDLE;
    end else begin
      case (state)
        FCFE_ST_IDLE: begin
          if (take && (req_op == FCFE_OP_VPP_ON || req_op == FCFE_OP_VPP_OFF)) begin
            state <= FCFE_ST_VPP;
          end else if (take) begin
            state <= FCFE_ST_SETUP;
          end
        end
        FCFE_ST_SETUP: begin
          if (tmr_if.expired) begin
            state <= FCFE_ST_STROBE;
          end
        end
        FCFE_ST_STROBE: begin
          if (tmr_if.expired) begin
            state <= FCFE_ST_HOLD;
          end
        end
        FCFE_ST_HOLD, FCFE_ST_VPP: begin
          if (tmr_if.expired) begin
            state <= FCFE_ST_DONE;
          end
        end
        FCFE_ST_DONE: begin
          state <= FCFE_ST_IDLE;
        end
        default: begin
          state <= FCFE_ST_IDLE;
        end
      endcase
    end
  end
  // Capture request fields while idle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      op <= FCFE_OP_READ;
      mem_addr <= '0;
      dq_out <= '0;
    end else if (take) begin
      op <= req_op;
      mem_addr <= req_addr;
      dq_out <= req_wdata;
    end
  end
  // Ready only in idle; registered from the next state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state == FCFE_ST_DONE) || (state == FCFE_ST_IDLE && !take);
    end
  end
  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Chip select spans setup, strobe and hold; a separate gate avoids contention
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      chip_sel_n <= 1'b1;
    end else begin
      chip_sel_n <= !((state == FCFE_ST_IDLE && take && (req_op == FCFE_OP_READ ||
                       req_op == FCFE_OP_WRITE)) || state == FCFE_ST_SETUP ||
                      state == FCFE_ST_STROBE ||
                      (state == FCFE_ST_HOLD && !tmr_if.expired));
    end
  end
  // Output gate only for reads, only during the strobe phase
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_gate_n <= 1'b1;
    end else begin
      out_gate_n <= !(op == FCFE_OP_READ && ((state == FCFE_ST_SETUP && tmr_if.expired) ||
                      (state == FCFE_ST_STROBE && !tmr_if.expired)));
    end
  end
  // Commands go out only through the write strobe; rising edge latches them
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_strobe_n <= 1'b1;
    end else begin
      wr_strobe_n <= !(op == FCFE_OP_WRITE && ((state == FCFE_ST_SETUP && tmr_if.expired) ||
                       (state == FCFE_ST_STROBE && !tmr_if.expired)));
    end
  end
  // Drive data through the whole write cycle so it is stable at strobe rise
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      dq_oe_n <= 1'b1;
    end else begin
      dq_oe_n <= !((state == FCFE_ST_IDLE && take && req_op == FCFE_OP_WRITE) ||
                   (op == FCFE_OP_WRITE && (state == FCFE_ST_SETUP ||
                    state == FCFE_ST_STROBE ||
                    (state == FCFE_ST_HOLD && !tmr_if.expired))));
    end
  end
  // Supply level; refused when hardware protection withholds it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      vpp_high <= 1'b0;
    end else if (take && req_op == FCFE_OP_VPP_ON) begin
      vpp_high <= vpp_allowed;
    end else if ((take && req_op == FCFE_OP_VPP_OFF) || !vpp_allowed) begin
      vpp_high <= 1'b0;
    end
  end
  // ----------------------------------------
  // Answer
  // ----------------------------------------
  // Sample data at access-time expiry; device returns the current command's data
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_rdata <= '0;
    end else if (op == FCFE_OP_READ && state == FCFE_ST_STROBE && tmr_if.expired) begin
      rsp_rdata <= dq_sync;
    end
  end
  // One-cycle completion pulse for every request kind
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rsp_valid <= 1'b0;
    end else begin
      rsp_valid <= (state == FCFE_ST_HOLD || state == FCFE_ST_VPP) && tmr_if.expired;
    end
  end
endmodule

// *** hdl/fcfe_pkg.sv ***
// Purpose: Constants and types for the flash command front-end host controller.
// Assumes: One clock (core_clk, 125 MHz), synchronous active-low reset.
// Notes: Timing figures are plain defaults; no command codes are fixed here.
//
// Summary of operation
// - Host writes commands with plain write cycles
// - Host reads array, verify and identifier data
// - Commands go only through write strobe
// - Host gates programming supply as protection
package fcfe_pkg;
  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int FCFE_ADDR_W = 17; // Address pins
  localparam int FCFE_DATA_W = 8; // Data pins
  // ----------------------------------------
  // Timing, in ns and in cycles
  // ----------------------------------------
  localparam int FCFE_CLK_PERIOD_NS = 8; // Core clock period
  localparam int FCFE_T_ACC_NS = 120; // Access time, least wait before sampling
  localparam int FCFE_T_WP_NS = 60; // Write strobe low width
  localparam int FCFE_T_SETUP_NS = 20; // Address setup before strobes
  localparam int FCFE_T_HOLD_NS = 20; // Hold after strobe rise
  localparam int FCFE_T_VPP_NS = 1000; // Supply settle time
  // Least times round up to whole cycles
  localparam int FCFE_ACC_CYC = (FCFE_T_ACC_NS + FCFE_CLK_PERIOD_NS - 1) / FCFE_CLK_PERIOD_NS;
  localparam int FCFE_WP_CYC = (FCFE_T_WP_NS + FCFE_CLK_PERIOD_NS - 1) / FCFE_CLK_PERIOD_NS;
  localparam int FCFE_SETUP_CYC = (FCFE_T_SETUP_NS + FCFE_CLK_PERIOD_NS - 1) / FCFE_CLK_PERIOD_NS;
  localparam int FCFE_HOLD_CYC = (FCFE_T_HOLD_NS + FCFE_CLK_PERIOD_NS - 1) / FCFE_CLK_PERIOD_NS;
  localparam int FCFE_VPP_CYC = (FCFE_T_VPP_NS + FCFE_CLK_PERIOD_NS - 1) / FCFE_CLK_PERIOD_NS;
  localparam int FCFE_CNT_W = 8; // Width of phase counter
  // ----------------------------------------
  // Cycle kinds and sequencer states
  // ----------------------------------------
  typedef enum logic [1:0] {
    FCFE_OP_READ = 2'h0, // Array, verify or identifier read
    FCFE_OP_WRITE = 2'h1, // Command write cycle
    FCFE_OP_VPP_ON = 2'h2, // Raise programming supply
    FCFE_OP_VPP_OFF = 2'h3 // Drop programming supply
  } fcfe_op_t;
  typedef enum logic [5:0] {
    FCFE_ST_IDLE = 6'h01, // Standby, nothing selected
    FCFE_ST_SETUP = 6'h02, // Address and select settle
    FCFE_ST_STROBE = 6'h04, // Gate or write strobe active
    FCFE_ST_HOLD = 6'h08, // Strobes released, select held
    FCFE_ST_VPP = 6'h10, // Waiting for supply to settle
    FCFE_ST_DONE = 6'h20 // One-cycle completion
  } fcfe_state_t;
endpackage

// *** hdl/fcfe_timer.sv ***
// Purpose: Down-counter timing each phase of a device cycle.
// Assumes: count is at least one.
// Notes: expired is high in the cycle after the count reaches one.
module fcfe_timer
  import fcfe_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  fcfe_timer_if.timer tmr
);
  // ----------------------------------------
  // Counter
  // ----------------------------------------
  logic [FCFE_CNT_W-1:0] remain; // Cycles still to wait
  // Load on request, otherwise count down to zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      remain <= '0;
    end else if (tmr.load) begin
      remain <= tmr.count;
    end else if (remain != '0) begin
      remain <= remain - 1'b1;
    end
  end
  // Expiry flag, high for one cycle after remain reaches one, then low while idle at zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tmr.expired <= 1'b0;
    end else begin
      tmr.expired <= !tmr.load && (remain == {{(FCFE_CNT_W-1){1'b0}}, 1'b1});
    end
  end
endmodule

// *** hdl/fcfe_timer_if.sv ***
// Purpose: Carrier between sequencer and phase timer.
// Assumes: Same clock domain on both ends.
// Notes: load starts a count; expired rises when it runs out.
interface fcfe_timer_if;
  import fcfe_pkg::*;
  logic load; // Start a new count
  logic [FCFE_CNT_W-1:0] count; // Cycles to wait
  logic expired; // Count finished
  modport owner (output load, output count, input expired);
  modport timer (input load, input count, output expired);
endinterface

// *** tb/fcfe_dev_model.sv ***
// Purpose: Behavioural flash front end answering fcfe_host pins.
// Assumes: Command codes are arbitrary; no erase or program algorithm.
// Notes: Released data pins show the inverse of the last value driven.
module fcfe_dev_model #(
  parameter int ADDR_W = 17,
  parameter logic [7:0] CMD_READ = 8'h00, // Arbitrary code
  parameter logic [7:0] CMD_VFY = 8'h3C, // Arbitrary code
  parameter logic [7:0] CMD_ID = 8'h6B, // Arbitrary code
  parameter logic [7:0] ID_CODE = 8'hD2 // Arbitrary value
) (
  input wire logic vpp_high,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic [7:0] dq_out,
  input wire logic dq_oe_n,
  output logic [7:0] dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cmd = 8'h00; // Command register
  logic [ADDR_W-1:0] lat_addr = '0; // Address latch
  logic [7:0] last = 8'h00; // Last value driven
  logic [7:0] rd; // Source picked by command
  wire drv = !chip_sel_n && !out_gate_n && dq_oe_n; // Selected, gated, host quiet
  // Capture only on strobe release under high supply; other writes are lost
  always @(posedge wr_strobe_n) begin
    if (!chip_sel_n && vpp_high) begin
      cmd = dq_out;
      lat_addr = mem_addr;
    end
  end
  // Supply removal falls back to plain reads
  always @(negedge vpp_high) cmd = CMD_READ;
  // Command picks what a read returns
  always_comb begin
    if (!vpp_high || cmd == CMD_READ) rd = mem_addr[7:0] ^ 8'h5A;
    else if (cmd == CMD_ID) rd = ID_CODE;
    else if (cmd == CMD_VFY) rd = lat_addr[7:0];
    else rd = mem_addr[7:0] ^ 8'h5A;
  end
  always @(drv or rd) if (drv) last = rd;
  // Wire level from both parties' enables
  assign dq_in = !dq_oe_n ? dq_out : (drv ? rd : ~last);
endmodule

// *** tb/fcfe_host_assertions.sv ***
// Purpose: Pin and handshake checks bound into fcfe_host.
// Assumes: One clock domain, synchronous active-low reset.
// Notes: Supply check leaves room for the 2-FF permission sync.
module fcfe_host_assertions #(
  parameter int ADDR_W = 17,
  parameter int DATA_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic wp_allow,
  input wire logic vpp_high,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic chip_sel_n,
  input wire logic out_gate_n,
  input wire logic wr_strobe_n,
  input wire logic [DATA_W-1:0] dq_out,
  input wire logic dq_oe_n
);
  timeunit 1ns;
  timeprecision 1ps;
  import fcfe_pkg::*;
  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  logic [7:0] gate_cyc; // Cycles the gate has been low
  // Count gate-low cycles so the access time is checked in full
  always_ff @(posedge core_clk) begin
    if (!rst_n || out_gate_n) gate_cyc <= 8'h00;
    else gate_cyc <= gate_cyc + 8'h01;
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    req_valid && req_ready;
  endsequence
  sequence s_answer;
    ##[1:200] rsp_valid;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  AST_ANSWER: assert property (s_take |-> s_answer)
    else $error("request not answered");
  AST_BUSY: assert property (s_take |=> !req_ready)
    else $error("ready stayed high after take");
  AST_PULSE: assert property (rsp_valid |=> !rsp_valid)
    else $error("response longer than one cycle");
  AST_GATE_SEL: assert property (!out_gate_n |-> !chip_sel_n && dq_oe_n && wr_strobe_n)
    else $error("gate low without select or with host driving");
  AST_STROBE_SEL: assert property (!wr_strobe_n |-> !chip_sel_n && !dq_oe_n)
    else $error("strobe low without select or data");
  AST_STROBE_W: assert property ($fell(wr_strobe_n) |-> (!wr_strobe_n) [*8])
    else $error("write strobe too short");
  AST_ACCESS: assert property ($rose(out_gate_n) |-> gate_cyc >= FCFE_ACC_CYC)
    else $error("gate released before access time");
  AST_ADDR_HOLD: assert property (!chip_sel_n && !$past(chip_sel_n) |-> $stable(mem_addr))
    else $error("address moved while selected");
  AST_LATCH: assert property ($rose(wr_strobe_n) |-> !chip_sel_n && $stable(dq_out))
    else $error("no hold at strobe release");
  AST_WP: assert property ((!wp_allow) [*4] |=> !vpp_high)
    else $error("supply high without permission");
endmodule
bind fcfe_host fcfe_host_assertions #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
  .core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid), .req_ready(req_ready),
  .rsp_valid(rsp_valid), .wp_allow(wp_allow), .vpp_high(vpp_high), .mem_addr(mem_addr),
  .chip_sel_n(chip_sel_n), .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n),
  .dq_out(dq_out), .dq_oe_n(dq_oe_n)
);

// *** tb/testbench.sv ***
// Purpose: Self-checking bench for fcfe_host against a device model.
// Assumes: Local command codes match the model's parameters.
// Notes: Every scenario is its own task.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcfe_pkg::*;
  localparam logic [7:0] VFY = 8'h3C; // Verify command, as in model
  localparam logic [7:0] IDC = 8'h6B; // Identifier command
  localparam logic [7:0] IDV = 8'hD2; // Identifier value
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  fcfe_op_t req_op = FCFE_OP_READ;
  logic [16:0] req_addr = 17'h00000;
  logic [7:0] req_wdata = 8'h00;
  logic wp_allow = 1'b0;
  logic req_ready, rsp_valid, vpp_high, chip_sel_n, out_gate_n, wr_strobe_n, dq_oe_n;
  logic [7:0] rsp_rdata, dq_in, dq_out;
  logic [16:0] mem_addr;
  int mismatches = 0;
  int checks_done = 0;
  fcfe_host dut (.core_clk(core_clk), .rst_n(rst_n), .req_valid(req_valid),
    .req_op(req_op), .req_addr(req_addr), .req_wdata(req_wdata), .wp_allow(wp_allow),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .vpp_high(vpp_high), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n));
  fcfe_dev_model u_dev (.vpp_high(vpp_high), .mem_addr(mem_addr), .chip_sel_n(chip_sel_n),
    .out_gate_n(out_gate_n), .wr_strobe_n(wr_strobe_n), .dq_out(dq_out),
    .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  task automatic wrap_up;
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input logic [16:0] seen, input logic [16:0] want);
    checks_done++;
    if (seen !== want) begin
      mismatches++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, want);
    end
  endtask
  // One request, waiting for ready and for the answer under a bound
  task automatic req(input fcfe_op_t op, input logic [16:0] a, input logic [7:0] d);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    req_op = op;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    @(posedge core_clk);
    #1;
    req_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 300) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    check(17'(rsp_valid), 17'h1);
    // Request fields stand on the pins until the next request is taken
    check(mem_addr, a);
    check(17'(dq_out), 17'(d));
    // Select, gate, strobe and data drive all released at completion
    check({13'h0, chip_sel_n, out_gate_n, wr_strobe_n, dq_oe_n}, 17'h0000F);
  endtask
  task automatic wait_cyc(input int c);
    repeat (c) @(posedge core_clk);
    #1;
  endtask
  // Without permission, supply stays low and writes are ignored
  task automatic t_readonly;
    wp_allow = 1'b0;
    req(FCFE_OP_VPP_ON, 17'h0, 8'h0);
    check(17'(vpp_high), 17'h0);
    req(FCFE_OP_WRITE, 17'h00012, IDC);
    req(FCFE_OP_READ, 17'h00034, 8'h0);
    check(17'(rsp_rdata), 17'h6E);
  endtask
  // Supply up, verify and identifier commands, then supply down
  task automatic t_program;
    wp_allow = 1'b1;
    wait_cyc(4);
    req(FCFE_OP_VPP_ON, 17'h0, 8'h0);
    check(17'(vpp_high), 17'h1);
    req(FCFE_OP_READ, 17'h1FFFF, 8'h0);
    check(17'(rsp_rdata), 17'hA5);
    req(FCFE_OP_WRITE, 17'h0ABCD, VFY);
    req(FCFE_OP_READ, 17'h00001, 8'h0);
    check(17'(rsp_rdata), 17'hCD);
    req(FCFE_OP_WRITE, 17'h0, IDC);
    req(FCFE_OP_READ, 17'h0, 8'h0);
    check(17'(rsp_rdata), 17'(IDV));
    req(FCFE_OP_VPP_OFF, 17'h0, 8'h0);
    check(17'(vpp_high), 17'h0);
    req(FCFE_OP_READ, 17'h00077, 8'h0);
    check(17'(rsp_rdata), 17'h2D);
  endtask
  // Permission dropped while high forces supply low
  task automatic t_wp_drop;
    req(FCFE_OP_VPP_ON, 17'h0, 8'h0);
    req(FCFE_OP_WRITE, 17'h0, IDC);
    wp_allow = 1'b0;
    wait_cyc(6);
    check(17'(vpp_high), 17'h0);
    req(FCFE_OP_READ, 17'h00010, 8'h0);
    check(17'(rsp_rdata), 17'h4A);
  endtask
  initial begin
    wait_cyc(3);
    check({11'h0, chip_sel_n, out_gate_n, wr_strobe_n, dq_oe_n, vpp_high, req_ready},
      17'h3C);
    wait_cyc(1);
    rst_n = 1'b1;
    t_readonly;
    t_program;
    t_wp_drop;
    wrap_up;
  end
  // Watchdog well beyond the expected run
  initial begin
    #100us;
    mismatches++;
    wrap_up;
  end
endmodule
